//--- rtl/fpcn_pkg.sv
// package: single-precision word layout, classes and exponent limits
package fpcn_pkg;

  // ==========================================================
  // word layout and raw result carrier
  // ==========================================================
  localparam int FPCN_EXP_W = 8;
  localparam int FPCN_FRAC_W = 23;
  localparam int FPCN_MANT_W = FPCN_FRAC_W + 1;
  localparam int FPCN_RAW_EXP_W = 10;
  localparam int FPCN_WIDE_EXP_W = FPCN_RAW_EXP_W + 1;
  localparam int FPCN_LZ_W = 5;
  localparam int FPCN_QUIET_BIT = FPCN_FRAC_W - 1;

  // sign bit 31, biased exponent 30..23, fraction 22..0
  typedef struct packed {
    logic sign;
    logic [FPCN_EXP_W-1:0] exp;
    logic [FPCN_FRAC_W-1:0] frac;
  } fpcn_word_s;

  // raw result from the pipeline: true exponent, explicit integer bit at the top of mant
  typedef struct packed {
    logic nan;
    logic inf;
    logic sign;
    logic signed [FPCN_RAW_EXP_W-1:0] exp;
    logic [FPCN_MANT_W-1:0] mant;
  } fpcn_raw_s;

  typedef enum logic [2:0] {
    FPCN_ZERO,
    FPCN_DENORM,
    FPCN_NORMAL,
    FPCN_INF,
    FPCN_QNAN,
    FPCN_SNAN
  } fpcn_class_e;

  // ==========================================================
  // exponent constants
  // ==========================================================
  localparam logic [FPCN_EXP_W-1:0] FPCN_EXP_ZERO = 8'h00;
  localparam logic [FPCN_EXP_W-1:0] FPCN_EXP_ALL1 = 8'hFF;
  localparam logic signed [FPCN_WIDE_EXP_W-1:0] FPCN_BIAS = 11'sh07F;
  localparam logic signed [FPCN_WIDE_EXP_W-1:0] FPCN_EXP_MIN = -11'sh07E;
  localparam logic signed [FPCN_WIDE_EXP_W-1:0] FPCN_EXP_MAX = 11'sh07F;
  localparam logic [FPCN_LZ_W-1:0] FPCN_SHIFT_ALL = 5'h19;
  localparam logic [FPCN_WIDE_EXP_W-1:0] FPCN_SHIFT_LIM = 11'h018;

endpackage : fpcn_pkg

//--- rtl/fpcn_core.sv
// classify, compare and normalize datapath for single-precision words
// Notes on behaviour
// - sign bit 0 means positive, 1 means negative.
// - significand is integer bit plus fraction; integer bit is implied in the word.
// - stored exponent equals true exponent plus 127.
// - leading zeros shifted out left, exponent decremented once per position.
// - biased exponent 1 to 254 classifies as normal finite.
// - exponent field 0 means integer bit zero: denormal, or zero if fraction zero.
// - plus and minus zero compare equal.
// - below -126, shift right one place per increment until -126: denormal.
// - if every bit is shifted out the result is zero.
// - results are normal whenever range allows; denormal only below minimum.
// - underflow flag raised whenever a denormal result is created.
// - denormal-operand flag raised when a source operand is denormal.
// - exponent 255 with zero fraction is infinity signed by sign bit.
// - exponent 255 with nonzero fraction is NaN, any sign.
// - NaN quiet when top fraction bit is one, signaling when zero.
// - a signaling NaN is never emitted as a result.
`timescale 1ns/1ps
`default_nettype none

module fpcn_core (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cls_valid,
  input wire fpcn_pkg::fpcn_word_s cls_op_a,
  input wire fpcn_pkg::fpcn_word_s cls_op_b,
  input wire logic norm_valid,
  input wire fpcn_pkg::fpcn_raw_s norm_raw,
  output logic cls_done,
  output fpcn_pkg::fpcn_class_e class_a,
  output fpcn_pkg::fpcn_class_e class_b,
  output logic op_equal,
  output logic denorm_op,
  output logic norm_done,
  output fpcn_pkg::fpcn_word_s norm_word,
  output logic underflow
);
  import fpcn_pkg::*;

  // ==========================================================
  // helper functions
  // ==========================================================
  function automatic fpcn_class_e fpcn_classify(input fpcn_word_s w);
    fpcn_class_e c;
    c = FPCN_NORMAL;
    if (w.exp == FPCN_EXP_ZERO) begin
      c = (w.frac == '0) ? FPCN_ZERO : FPCN_DENORM;
    end else if (w.exp == FPCN_EXP_ALL1) begin
      if (w.frac == '0) begin
        c = FPCN_INF;
      end else begin
        c = w.frac[FPCN_QUIET_BIT] ? FPCN_QNAN : FPCN_SNAN;
      end
    end
    return c;
  endfunction : fpcn_classify

  function automatic logic [FPCN_LZ_W-1:0] fpcn_lzc(input logic [FPCN_MANT_W-1:0] m);
    logic [FPCN_LZ_W-1:0] n;
    logic hit;
    n = '0;
    hit = 1'b0;
    for (int i = FPCN_MANT_W - 1; i >= 0; i--) begin
      if (!hit && m[i]) begin
        hit = 1'b1;
      end else if (!hit) begin
        n = n + 1'b1;
      end
    end
    return n;
  endfunction : fpcn_lzc

  function automatic logic fpcn_is_nan(input fpcn_class_e c);
    return (c == FPCN_QNAN) || (c == FPCN_SNAN);
  endfunction : fpcn_is_nan

  // ==========================================================
  // classify and compare
  // ==========================================================
  fpcn_class_e nxt_class_a;
  fpcn_class_e nxt_class_b;
  logic nxt_equal;
  logic nxt_denorm_op;

  assign nxt_class_a = fpcn_classify(cls_op_a);
  assign nxt_class_b = fpcn_classify(cls_op_b);
  // zeros match whatever their sign; NaN never matches
  assign nxt_equal = ((nxt_class_a == FPCN_ZERO) && (nxt_class_b == FPCN_ZERO)) ||
                     (!fpcn_is_nan(nxt_class_a) && !fpcn_is_nan(nxt_class_b) && (cls_op_a == cls_op_b));
  assign nxt_denorm_op = cls_valid && ((nxt_class_a == FPCN_DENORM) || (nxt_class_b == FPCN_DENORM));

  // ==========================================================
  // normalize and gradual underflow
  // ==========================================================
  logic [FPCN_LZ_W-1:0] lead_zeros;
  logic signed [FPCN_WIDE_EXP_W-1:0] adj_exp;
  logic [FPCN_MANT_W-1:0] mant_left;
  logic tiny;
  logic huge;
  logic [FPCN_WIDE_EXP_W-1:0] right_dist;
  logic [FPCN_LZ_W-1:0] right_sh;
  logic [FPCN_MANT_W-1:0] mant_right;
  logic [FPCN_WIDE_EXP_W-1:0] biased_exp;
  logic mant_zero;
  fpcn_word_s nxt_norm_word;
  logic nxt_underflow;

  assign mant_zero = (norm_raw.mant == '0);
  assign lead_zeros = fpcn_lzc(norm_raw.mant);
  assign mant_left = norm_raw.mant << lead_zeros;
  assign adj_exp = FPCN_WIDE_EXP_W'(norm_raw.exp) - $signed(FPCN_WIDE_EXP_W'(lead_zeros));
  assign tiny = !mant_zero && (adj_exp < FPCN_EXP_MIN);
  assign huge = !mant_zero && (adj_exp > FPCN_EXP_MAX);
  assign right_dist = FPCN_WIDE_EXP_W'(FPCN_EXP_MIN - adj_exp);
  // beyond the width every bit is gone, so clamp rather than carry a wide shifter
  assign right_sh = (right_dist > FPCN_SHIFT_LIM) ? FPCN_SHIFT_ALL : right_dist[FPCN_LZ_W-1:0];
  assign mant_right = mant_left >> right_sh;
  assign biased_exp = FPCN_WIDE_EXP_W'(adj_exp + FPCN_BIAS);

  always_comb begin
    nxt_norm_word.sign = norm_raw.sign;
    nxt_norm_word.exp = biased_exp[FPCN_EXP_W-1:0];
    nxt_norm_word.frac = mant_left[FPCN_FRAC_W-1:0];
    nxt_underflow = 1'b0;
    if (norm_raw.nan) begin
      // payload kept, quiet bit forced so a signaling code never leaves
      nxt_norm_word.exp = FPCN_EXP_ALL1;
      nxt_norm_word.frac = norm_raw.mant[FPCN_FRAC_W-1:0];
      nxt_norm_word.frac[FPCN_QUIET_BIT] = 1'b1;
    end else if (norm_raw.inf || huge) begin
      nxt_norm_word.exp = FPCN_EXP_ALL1;
      nxt_norm_word.frac = '0;
    end else if (mant_zero) begin
      nxt_norm_word.exp = FPCN_EXP_ZERO;
      nxt_norm_word.frac = '0;
    end else if (tiny) begin
      nxt_norm_word.exp = FPCN_EXP_ZERO;
      nxt_norm_word.frac = mant_right[FPCN_FRAC_W-1:0];
      nxt_underflow = 1'b1;
    end
  end

  // ==========================================================
  // output registers
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cls_done <= 1'b0;
      class_a <= FPCN_ZERO;
      class_b <= FPCN_ZERO;
      op_equal <= 1'b0;
      denorm_op <= 1'b0;
    end else begin
      cls_done <= cls_valid;
      class_a <= nxt_class_a;
      class_b <= nxt_class_b;
      op_equal <= nxt_equal;
      denorm_op <= nxt_denorm_op;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      norm_done <= 1'b0;
      norm_word <= '0;
      underflow <= 1'b0;
    end else begin
      norm_done <= norm_valid;
      norm_word <= nxt_norm_word;
      underflow <= norm_valid && nxt_underflow;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_sign_follows;
    norm_valid && !norm_raw.nan |=> norm_word.sign == $past(norm_raw.sign);
  endproperty
  a_sign_follows: assert property (p_sign_follows)
    else $error("result sign differs from raw sign");

  property p_normal_exp;
    norm_valid && !norm_raw.nan && !norm_raw.inf && norm_raw.mant[FPCN_MANT_W-1]
      && norm_raw.exp >= FPCN_EXP_MIN && norm_raw.exp <= FPCN_EXP_MAX
      |=> norm_word.exp == FPCN_EXP_W'($past(norm_raw.exp) + FPCN_BIAS) && !underflow;
  endproperty
  a_normal_exp: assert property (p_normal_exp)
    else $error("normal result exponent not biased by 127");

  property p_left_shift;
    norm_valid && !norm_raw.nan && !norm_raw.inf && norm_raw.mant == 24'h40_0001 && norm_raw.exp == 10'sh000
      |=> norm_word.exp == 8'h7E && norm_word.frac == 23'h00_0002;
  endproperty
  a_left_shift: assert property (p_left_shift)
    else $error("one leading zero not removed with exponent step");

  property p_normal_class;
    cls_valid && cls_op_a.exp != FPCN_EXP_ZERO && cls_op_a.exp != FPCN_EXP_ALL1 |=> class_a == FPCN_NORMAL;
  endproperty
  a_normal_class: assert property (p_normal_class)
    else $error("in-range exponent not classed normal");

  property p_zero_denorm_class;
    cls_valid && cls_op_b.exp == FPCN_EXP_ZERO
      |=> class_b == (($past(cls_op_b.frac) == '0) ? FPCN_ZERO : FPCN_DENORM);
  endproperty
  a_zero_denorm_class: assert property (p_zero_denorm_class)
    else $error("zero exponent word misclassed");

  property p_signed_zero_eq;
    cls_valid && cls_op_a.exp == FPCN_EXP_ZERO && cls_op_a.frac == '0
      && cls_op_b.exp == FPCN_EXP_ZERO && cls_op_b.frac == '0 |=> op_equal;
  endproperty
  a_signed_zero_eq: assert property (p_signed_zero_eq)
    else $error("signed zeros compared unequal");

  property p_uf_denormal;
    // judged on the exponent after leading zeros are removed: a raw exponent in range can still be tiny
    underflow |-> norm_done && norm_word.exp == FPCN_EXP_ZERO && $past(adj_exp) < FPCN_EXP_MIN;
  endproperty
  a_uf_denormal: assert property (p_uf_denormal)
    else $error("underflow without a tiny result");

  property p_tiny_shift;
    norm_valid && !norm_raw.nan && !norm_raw.inf && norm_raw.mant == 24'h80_0000 && norm_raw.exp == -10'sh080
      |=> underflow && norm_word.frac == 23'h20_0000;
  endproperty
  a_tiny_shift: assert property (p_tiny_shift)
    else $error("gradual underflow shift wrong");

  property p_flush_zero;
    norm_valid && !norm_raw.nan && !norm_raw.inf && norm_raw.mant != '0 && norm_raw.exp < -10'sh0A0
      |=> norm_word.exp == FPCN_EXP_ZERO && norm_word.frac == '0;
  endproperty
  a_flush_zero: assert property (p_flush_zero)
    else $error("fully shifted result not zero");

  property p_denorm_op;
    cls_valid && cls_op_a.exp == FPCN_EXP_ZERO && cls_op_a.frac != '0 |=> denorm_op && cls_done;
  endproperty
  a_denorm_op: assert property (p_denorm_op)
    else $error("denormal operand not flagged");

  property p_inf_class;
    cls_valid && cls_op_a.exp == FPCN_EXP_ALL1 |=>
      class_a == (($past(cls_op_a.frac) == '0) ? FPCN_INF :
                  ($past(cls_op_a.frac[FPCN_QUIET_BIT]) ? FPCN_QNAN : FPCN_SNAN));
  endproperty
  a_inf_class: assert property (p_inf_class)
    else $error("max exponent word misclassed");

  property p_no_snan_out;
    norm_done && norm_word.exp == FPCN_EXP_ALL1 && norm_word.frac != '0 |-> norm_word.frac[FPCN_QUIET_BIT];
  endproperty
  a_no_snan_out: assert property (p_no_snan_out)
    else $error("signaling NaN emitted");

  c_underflow: cover property (norm_valid ##1 underflow);
  c_denorm_op: cover property (cls_valid ##1 denorm_op);
  c_zero_eq: cover property (cls_valid ##1 op_equal && class_a == FPCN_ZERO && class_a == class_b);
  c_nan_quiet: cover property (norm_valid && norm_raw.nan ##1 norm_done);

endmodule : fpcn_core

`default_nettype wire

//--- tb/fpcn_pipe_model.sv
// pipeline-side model that presents classify and normalize requests
`timescale 1ns/1ps
`default_nettype none

module fpcn_pipe_model (
  input wire logic sys_clk,
  output logic cls_valid,
  output fpcn_pkg::fpcn_word_s cls_op_a,
  output fpcn_pkg::fpcn_word_s cls_op_b,
  output logic norm_valid,
  output fpcn_pkg::fpcn_raw_s norm_raw
);
  import fpcn_pkg::*;

  initial begin
    cls_valid = 1'b0;
    norm_valid = 1'b0;
    cls_op_a = '0;
    cls_op_b = '0;
    norm_raw = '0;
  end

  // ==========================================================
  // one request slot per edge
  // ==========================================================
  // idle operands are inverted so a stale word never passes for a live one
  task automatic send(input logic cv, input fpcn_word_s a, input fpcn_word_s b,
                      input logic nv, input fpcn_raw_s r);
    @(posedge sys_clk);
    cls_valid <= cv;
    cls_op_a <= cv ? a : ~cls_op_a;
    cls_op_b <= cv ? b : ~cls_op_b;
    norm_valid <= nv;
    norm_raw <= nv ? r : ~norm_raw;
  endtask : send
endmodule : fpcn_pipe_model

`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the classify and normalize datapath
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
  import fpcn_pkg::*;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cls_valid;
  logic norm_valid;
  fpcn_word_s cls_op_a;
  fpcn_word_s cls_op_b;
  fpcn_raw_s norm_raw;
  logic cls_done;
  fpcn_class_e class_a;
  fpcn_class_e class_b;
  logic op_equal;
  logic denorm_op;
  logic norm_done;
  fpcn_word_s norm_word;
  logic underflow;
  int fail_count = 0;
  int tests_run = 0;

  always #4 sys_clk = ~sys_clk;

  fpcn_pipe_model u_fpcn_pipe_model (
    .sys_clk(sys_clk), .cls_valid(cls_valid), .cls_op_a(cls_op_a), .cls_op_b(cls_op_b),
    .norm_valid(norm_valid), .norm_raw(norm_raw));

  fpcn_core u_fpcn_core (
    .sys_clk(sys_clk), .reset(reset), .cls_valid(cls_valid), .cls_op_a(cls_op_a),
    .cls_op_b(cls_op_b), .norm_valid(norm_valid), .norm_raw(norm_raw),
    .cls_done(cls_done), .class_a(class_a), .class_b(class_b), .op_equal(op_equal),
    .denorm_op(denorm_op), .norm_done(norm_done), .norm_word(norm_word),
    .underflow(underflow));

  // ==========================================================
  // expectation tables
  // ==========================================================
  fpcn_word_s cw [10] = '{32'h0000_0000, 32'h0000_0001, 32'h007F_FFFF, 32'h0080_0000,
    32'h7F7F_FFFF, 32'h7F80_0000, 32'h7FC0_0000, 32'h7F80_0001, 32'hFFBF_FFFF, 32'h4332_2000};
  fpcn_class_e cc [10] = '{FPCN_ZERO, FPCN_DENORM, FPCN_DENORM, FPCN_NORMAL, FPCN_NORMAL,
    FPCN_INF, FPCN_QNAN, FPCN_SNAN, FPCN_SNAN, FPCN_NORMAL};
  // {nan inf sign, true exp, mant, word, underflow}
  logic [69:0] nt [15] = '{
    {3'h0, 10'h000, 24'h80_0000, 32'h3F80_0000, 1'b0},
    {3'h0, 10'h000, 24'h40_0000, 32'h3F00_0000, 1'b0},
    {3'h1, 10'h001, 24'hC0_0000, 32'hC040_0000, 1'b0},
    {3'h0, 10'h382, 24'h80_0000, 32'h0080_0000, 1'b0},
    {3'h0, 10'h381, 24'h80_0000, 32'h0040_0000, 1'b1},
    {3'h0, 10'h380, 24'h80_0000, 32'h0020_0000, 1'b1},
    {3'h0, 10'h36B, 24'h80_0000, 32'h0000_0001, 1'b1},
    {3'h0, 10'h36A, 24'h80_0000, 32'h0000_0000, 1'b1},
    {3'h1, 10'h000, 24'h00_0000, 32'h8000_0000, 1'b0},
    {3'h4, 10'h000, 24'h00_0001, 32'h7FC0_0001, 1'b0},
    {3'h3, 10'h000, 24'h80_0000, 32'hFF80_0000, 1'b0},
    {3'h0, 10'h080, 24'h80_0000, 32'h7F80_0000, 1'b0},
    {3'h0, 10'h383, 24'h00_0001, 32'h0000_0002, 1'b1},
    {3'h0, 10'h000, 24'h40_0001, 32'h3F00_0002, 1'b0},
    {3'h0, 10'h35F, 24'hFF_FFFF, 32'h0000_0000, 1'b1}};
  // {operand a, operand b, equal}: identical words match unless NaN
  fpcn_word_s ea [4] = '{32'h4332_2000, 32'h7FC0_0000, 32'h0000_0000, 32'hFF80_0000};
  fpcn_word_s eb [4] = '{32'h4332_2000, 32'h7FC0_0000, 32'h0000_0001, 32'hFF80_0000};
  logic eq [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  // ==========================================================
  // scenarios
  // ==========================================================
  // back to back: edge i launches entry i while entry i-1 is judged
  task automatic t_class();
    for (int i = 0; i <= 10; i++) begin
      if (i < 10) u_fpcn_pipe_model.send(1'b1, cw[i], cw[i] ^ 32'h8000_0000, 1'b0, '0);
      else u_fpcn_pipe_model.send(1'b0, '0, '0, 1'b0, '0);
      #1;
      if (i > 0) begin
        `CHK(cls_done, 1'b1)
        `CHK(class_a, cc[i-1])
        `CHK(class_b, cc[i-1])
        `CHK(op_equal, cc[i-1] == FPCN_ZERO)
        `CHK(denorm_op, cc[i-1] == FPCN_DENORM)
      end
    end
    u_fpcn_pipe_model.send(1'b0, '0, '0, 1'b0, '0);
    #1;
    `CHK(cls_done, 1'b0)
    $display("t_class done");
  endtask : t_class

  task automatic t_equal();
    for (int i = 0; i <= 4; i++) begin
      if (i < 4) u_fpcn_pipe_model.send(1'b1, ea[i], eb[i], 1'b0, '0);
      else u_fpcn_pipe_model.send(1'b0, '0, '0, 1'b0, '0);
      #1;
      if (i > 0) begin
        `CHK(cls_done, 1'b1)
        `CHK(op_equal, eq[i-1])
        `CHK(denorm_op, eb[i-1] == 32'h0000_0001)
      end
    end
    $display("t_equal done");
  endtask : t_equal

  task automatic t_norm();
    for (int i = 0; i <= 15; i++) begin
      if (i < 15) u_fpcn_pipe_model.send(1'b0, '0, '0, 1'b1, nt[i][69:33]);
      else u_fpcn_pipe_model.send(1'b0, '0, '0, 1'b0, '0);
      #1;
      if (i > 0) begin
        `CHK(norm_done, 1'b1)
        `CHK(norm_word, nt[i-1][32:1])
        `CHK(underflow, nt[i-1][0])
      end
    end
    u_fpcn_pipe_model.send(1'b0, '0, '0, 1'b0, '0);
    #1;
    `CHK(norm_done, 1'b0)
    $display("t_norm done");
  endtask : t_norm

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(cls_done, 1'b0)
    `CHK(class_a, FPCN_ZERO)
    `CHK(norm_word, 32'h0000_0000)
    @(posedge sys_clk);
    reset <= 1'b0;
    t_class();
    t_equal();
    t_norm();
    print_verdict();
  end

  // whole run is about forty cycles; a margin of over twelvefold marks a hang
  initial begin
    repeat (500) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
